// ### verilog/tcs_cfg.svh
// constants of the tape command sequencer
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// ****************************************
// command codes
// ****************************************
`define TCS_CMD_DESEL 8'h00
`define TCS_CMD_SEL 8'h01
`define TCS_CMD_REWIND 8'h21
`define TCS_CMD_ERASE 8'h22
`define TCS_CMD_RETEN 8'h24
`define TCS_CMD_WRITE 8'h40
`define TCS_CMD_WFMARK 8'h60
`define TCS_CMD_READ 8'h80
`define TCS_CMD_SKIPFM 8'hA0
`define TCS_CMD_EOTPOS 8'hA3
`define TCS_CMD_SENSE 8'hC0
`define TCS_CMD_STATS 8'hC1
`define TCS_CMD_BLKID 8'hC2

// ****************************************
// error codes held for the sense request
// ****************************************
`define TCS_ERR_NONE 8'h00
`define TCS_ERR_BADCMD 8'h01
`define TCS_ERR_SEQ 8'h02
`define TCS_ERR_NOTSEL 8'h03
`define TCS_ERR_CHANGED 8'h04
`define TCS_ERR_EOF 8'h05
`define TCS_ERR_DRIVE 8'h06

// ****************************************
// poll answers: error, not yet done, done
// ****************************************
`define TCS_POLL_ERR 2'h3
`define TCS_POLL_BUSY 2'h0
`define TCS_POLL_DONE 2'h1

// ****************************************
// sizes and timing
// ****************************************
`define TCS_BLK_LAST 9'h1FF
`define TCS_SENSE_LEN 24'h00_0008
`define TCS_RETEN_STEPS 2'h2
`define TCS_CLK_NS 4
`define TCS_INIT_TIME_NS 10000
`define TCS_INIT_CYC (`TCS_INIT_TIME_NS / `TCS_CLK_NS)

`endif

// ### verilog/tcs_pkg.sv
// types of the tape command sequencer
package tcs_pkg;

	typedef enum logic [3:0] {
		TCS_ST_IDLE,
		TCS_ST_INIT,
		TCS_ST_MOTION,
		TCS_ST_WRITE,
		TCS_ST_READ,
		TCS_ST_SENSE,
		TCS_ST_DONE,
		TCS_ST_ERR
	} tcs_state_e;

	typedef enum logic [2:0] {
		TCS_MOT_BOT,
		TCS_MOT_EOT,
		TCS_MOT_ERASE,
		TCS_MOT_FMARK,
		TCS_MOT_SKIPFM,
		TCS_MOT_EODPOS
	} tcs_mot_e;

endpackage : tcs_pkg

// ### verilog/tcs_sequencer.sv
// command sequencer of the cartridge tape controller
`timescale 1ns/10ps
`default_nettype none
`include "tcs_cfg.svh"

// Functional notes
// - code 00H drops drive select
// - reselect after deselect marks tape changed
// - code 01H raises drive select
// - code 21H rewinds tape to start
// - rewind required after insertion before read/write
// - code 22H writes end-of-data at start
// - code 24H: start, end, start again
// - code 40H writes 512-byte blocks while fed
// - write mode ends only on terminate or init
// - code 60H writes a file mark
// - code 80H reads 512-byte blocks while asked
// - read mode ends on error or terminate
// - end-of-file error only after whole block
// - at file mark, reads keep failing EOF
// - code A0H skips past next file mark
// - poll answers at once: error, busy, done
// - transfer errors shown at poll or terminate
// - initialization fails only if reset fails
// - code C0H sends sense, clears error, count
// - sense and statistics move exactly eight bytes
module tcs_sequencer
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// host command handshakes
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	output logic cmd_ack,
	output logic cmd_err,
	input wire logic xfer_valid,
	input wire logic [23:0] xfer_bytes,
	output logic xfer_ack,
	output logic xfer_err,
	input wire logic poll_valid,
	output logic poll_ack,
	output logic [1:0] poll_code,
	input wire logic term_valid,
	output logic term_ack,
	output logic term_err,
	input wire logic init_valid,
	output logic init_ack,
	output logic init_fail,
	output logic busy,
	// host data, memory to tape
	input wire logic hw_valid,
	input wire logic [7:0] hw_data,
	output logic hw_ready,
	// host data, tape to memory
	output logic hr_valid,
	output logic [7:0] hr_data,
	input wire logic hr_ready,
	// drive control
	output logic drive_select,
	output logic drive_reset,
	input wire logic drive_ready,
	input wire logic cart_present,
	output logic mot_start,
	output tcs_pkg::tcs_mot_e mot_op,
	input wire logic mot_done,
	input wire logic mot_err,
	// drive data
	output logic tw_valid,
	output logic [7:0] tw_data,
	output logic tw_last,
	input wire logic tw_ready,
	input wire logic tr_valid,
	input wire logic [7:0] tr_data,
	input wire logic tr_fmark,
	output logic tr_ready
);
	import tcs_pkg::*;

	localparam logic [11:0] INIT_CYC = 12'(`TCS_INIT_CYC);

	// ****************************************
	// decoding
	// ****************************************
	function automatic logic code_known(input logic [7:0] c);
		case (c)
			`TCS_CMD_DESEL, `TCS_CMD_SEL, `TCS_CMD_REWIND, `TCS_CMD_ERASE,
			`TCS_CMD_RETEN, `TCS_CMD_WRITE, `TCS_CMD_WFMARK, `TCS_CMD_READ,
			`TCS_CMD_SKIPFM, `TCS_CMD_EOTPOS, `TCS_CMD_SENSE,
			`TCS_CMD_STATS, `TCS_CMD_BLKID:
				code_known = 1'b1;
			default:
				code_known = 1'b0;
		endcase
	endfunction : code_known

	// byte i of a snapshot, most significant first
	function automatic logic [7:0] snap_byte(input logic [63:0] s,
		input logic [2:0] i);
		logic [63:0] t;
		t = s << {i, 3'b000};
		snap_byte = t[63:56];
	endfunction : snap_byte

	// ****************************************
	// state
	// ****************************************
	tcs_state_e state_reg, state_next;
	tcs_mot_e mot_op_reg, mot_op_next;
	logic [1:0] step_reg, step_next;
	logic [23:0] remain_reg, remain_next;
	logic [8:0] bib_reg, bib_next;
	logic [23:0] blk_reg, blk_next;
	logic [7:0] err_code_reg, err_code_next;
	logic [63:0] snap_reg, snap_next;
	logic [2:0] sidx_reg, sidx_next;
	logic [11:0] itmr_reg, itmr_next;
	logic sel_reg, sel_next;
	logic desel_seen_reg, desel_seen_next;
	logic chg_reg, chg_next;
	logic at_eof_reg, at_eof_next;
	logic cart_q_reg, cart_q_next;
	logic term_pend_reg, term_pend_next;
	logic busy_reg, busy_next;
	logic cmd_ack_reg, cmd_ack_next, cmd_err_reg, cmd_err_next;
	logic xfer_ack_reg, xfer_ack_next, xfer_err_reg, xfer_err_next;
	logic poll_ack_reg, poll_ack_next;
	logic [1:0] poll_code_reg, poll_code_next;
	logic term_ack_reg, term_ack_next, term_err_reg, term_err_next;
	logic init_ack_reg, init_ack_next, init_fail_reg, init_fail_next;
	logic hw_ready_reg, hw_ready_next, tr_ready_reg, tr_ready_next;
	logic hr_valid_reg, hr_valid_next, tw_valid_reg, tw_valid_next;
	logic tw_last_reg, tw_last_next;
	logic [7:0] hr_data_reg, hr_data_next, tw_data_reg, tw_data_next;
	logic drv_rst_reg, drv_rst_next, mot_start_reg, mot_start_next;

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		logic step;
		step = 1'b0;
		state_next = state_reg;
		mot_op_next = mot_op_reg;
		step_next = step_reg;
		remain_next = remain_reg;
		bib_next = bib_reg;
		blk_next = blk_reg;
		err_code_next = err_code_reg;
		snap_next = snap_reg;
		sidx_next = sidx_reg;
		itmr_next = itmr_reg;
		sel_next = sel_reg;
		desel_seen_next = desel_seen_reg;
		chg_next = chg_reg;
		at_eof_next = at_eof_reg;
		cart_q_next = cart_present;
		term_pend_next = term_pend_reg | term_valid;
		busy_next = busy_reg;
		cmd_ack_next = 1'b0;
		cmd_err_next = 1'b0;
		xfer_ack_next = 1'b0;
		xfer_err_next = 1'b0;
		poll_ack_next = 1'b0;
		poll_code_next = poll_code_reg;
		term_ack_next = 1'b0;
		term_err_next = term_err_reg;
		init_ack_next = 1'b0;
		init_fail_next = init_fail_reg;
		hr_valid_next = hr_valid_reg & ~hr_ready;
		hr_data_next = hr_data_reg;
		tw_valid_next = tw_valid_reg & ~tw_ready;
		tw_data_next = tw_data_reg;
		tw_last_next = tw_last_reg;
		drv_rst_next = drv_rst_reg;
		mot_start_next = 1'b0;

		// a new cartridge must be rewound before use
		if (cart_present && !cart_q_reg)
			chg_next = 1'b1;

		// data paths
		if (hw_valid && hw_ready_reg)
		begin
			tw_valid_next = 1'b1;
			tw_data_next = hw_data;
			tw_last_next = (bib_reg == `TCS_BLK_LAST);
			step = 1'b1;
		end
		if (tr_valid && tr_ready_reg)
		begin
			hr_valid_next = 1'b1;
			hr_data_next = tr_data;
			step = 1'b1;
		end
		if (step)
		begin
			remain_next = remain_reg - 24'h00_0001;
			bib_next = bib_reg + 9'h001;
			if (bib_reg == `TCS_BLK_LAST)
				blk_next = blk_reg + 24'h00_0001;
		end
		// a file mark is only honoured between blocks
		if (state_reg == TCS_ST_READ && remain_reg != 24'h00_0000 &&
			bib_reg == 9'h000 && tr_fmark && !step)
		begin
			state_next = TCS_ST_ERR;
			at_eof_next = 1'b1;
			err_code_next = `TCS_ERR_EOF;
		end
		if (state_reg == TCS_ST_SENSE && remain_reg != 24'h00_0000 &&
			!hr_valid_next)
		begin
			hr_valid_next = 1'b1;
			hr_data_next = snap_byte(snap_reg, sidx_reg);
			sidx_next = sidx_reg + 3'h1;
			remain_next = remain_reg - 24'h00_0001;
		end

		// motion completion and retension phases
		if (state_reg == TCS_ST_MOTION && mot_done)
		begin
			if (mot_err)
			begin
				state_next = TCS_ST_ERR;
				err_code_next = `TCS_ERR_DRIVE;
			end
			else if (step_reg != 2'h0)
			begin
				mot_start_next = 1'b1;
				mot_op_next = (step_reg == `TCS_RETEN_STEPS) ?
					TCS_MOT_EOT : TCS_MOT_BOT;
				step_next = step_reg - 2'h1;
			end
			else
			begin
				state_next = TCS_ST_DONE;
				if (mot_op_reg == TCS_MOT_BOT)
				begin
					chg_next = 1'b0;
					at_eof_next = 1'b0;
				end
				if (mot_op_reg == TCS_MOT_SKIPFM)
					at_eof_next = 1'b0;
			end
		end

		// controller initialization
		if (state_reg == TCS_ST_INIT)
		begin
			itmr_next = itmr_reg - 12'h001;
			if (drive_ready || itmr_reg == 12'h000)
			begin
				drv_rst_next = 1'b0;
				init_ack_next = 1'b1;
				init_fail_next = !drive_ready;
				state_next = TCS_ST_IDLE;
			end
		end

		// command acceptance
		if (cmd_valid && state_reg != TCS_ST_INIT)
		begin
			cmd_ack_next = 1'b1;
			if (!code_known(cmd_code))
			begin
				cmd_err_next = 1'b1;
				err_code_next = `TCS_ERR_BADCMD;
			end
			else if (busy_reg)
			begin
				cmd_err_next = 1'b1;
				err_code_next = `TCS_ERR_SEQ;
			end
			else
			begin
				busy_next = 1'b1;
				remain_next = 24'h00_0000;
				bib_next = 9'h000;
				sidx_next = 3'h0;
				step_next = 2'h0;
				state_next = TCS_ST_MOTION;
				case (cmd_code)
					`TCS_CMD_DESEL:
					begin
						sel_next = 1'b0;
						desel_seen_next = 1'b1;
						state_next = TCS_ST_DONE;
					end
					`TCS_CMD_SEL:
					begin
						sel_next = 1'b1;
						chg_next = chg_next | desel_seen_reg;
						desel_seen_next = 1'b0;
						state_next = TCS_ST_DONE;
					end
					`TCS_CMD_REWIND:
						mot_op_next = TCS_MOT_BOT;
					`TCS_CMD_RETEN:
					begin
						mot_op_next = TCS_MOT_BOT;
						step_next = `TCS_RETEN_STEPS;
					end
					`TCS_CMD_ERASE:
						mot_op_next = TCS_MOT_ERASE;
					`TCS_CMD_WFMARK:
						mot_op_next = TCS_MOT_FMARK;
					`TCS_CMD_SKIPFM:
						mot_op_next = TCS_MOT_SKIPFM;
					`TCS_CMD_EOTPOS:
						mot_op_next = TCS_MOT_EODPOS;
					`TCS_CMD_WRITE:
						state_next = TCS_ST_WRITE;
					`TCS_CMD_READ:
						state_next = TCS_ST_READ;
					`TCS_CMD_SENSE:
					begin
						snap_next = {err_code_next, blk_reg, chg_next,
							7'h00, 24'h00_0000};
						err_code_next = `TCS_ERR_NONE;
						blk_next = 24'h00_0000;
						state_next = TCS_ST_SENSE;
					end
					default:
					begin
						// statistics and block id are not kept here
						snap_next = 64'h0000_0000_0000_0000;
						state_next = TCS_ST_SENSE;
					end
				endcase
				// drive must be selected and rewound first
				if (state_next != TCS_ST_DONE &&
					state_next != TCS_ST_SENSE)
				begin
					if (!sel_reg)
					begin
						state_next = TCS_ST_ERR;
						err_code_next = `TCS_ERR_NOTSEL;
					end
					else if (chg_next && cmd_code != `TCS_CMD_REWIND &&
						cmd_code != `TCS_CMD_RETEN)
					begin
						state_next = TCS_ST_ERR;
						err_code_next = `TCS_ERR_CHANGED;
					end
					else if (cmd_code == `TCS_CMD_READ && at_eof_reg)
					begin
						state_next = TCS_ST_ERR;
						err_code_next = `TCS_ERR_EOF;
					end
				end
				mot_start_next = (state_next == TCS_ST_MOTION);
			end
		end

		// transfer start: errors wait for poll or terminate
		if (xfer_valid)
		begin
			xfer_ack_next = 1'b1;
			if ((state_reg == TCS_ST_WRITE || state_reg == TCS_ST_READ)
				&& remain_reg == 24'h00_0000)
				remain_next = xfer_bytes;
			else if (state_reg == TCS_ST_SENSE &&
				remain_reg == 24'h00_0000 && sidx_reg == 3'h0)
				remain_next = `TCS_SENSE_LEN;
			else if (state_reg != TCS_ST_ERR)
				xfer_err_next = 1'b1;
		end

		// completion poll, answered on the next edge
		if (poll_valid)
		begin
			poll_ack_next = 1'b1;
			case (state_reg)
				TCS_ST_ERR, TCS_ST_IDLE:
					poll_code_next = `TCS_POLL_ERR;
				TCS_ST_DONE:
					poll_code_next = `TCS_POLL_DONE;
				TCS_ST_WRITE, TCS_ST_READ, TCS_ST_SENSE:
					poll_code_next = (remain_reg == 24'h00_0000 &&
						!tw_valid_reg && !hr_valid_reg) ?
						`TCS_POLL_DONE : `TCS_POLL_BUSY;
				default:
					poll_code_next = `TCS_POLL_BUSY;
			endcase
		end

		// terminate waits for motion and queued bytes to finish
		if (term_pend_reg && state_reg != TCS_ST_MOTION &&
			state_reg != TCS_ST_INIT && !tw_valid_reg && !hr_valid_reg &&
			!(state_reg == TCS_ST_SENSE && remain_reg != 24'h00_0000))
		begin
			term_ack_next = 1'b1;
			term_err_next = (state_reg == TCS_ST_ERR);
			// a fresh terminate in this cycle must not be lost
			term_pend_next = term_valid;
			busy_next = 1'b0;
			state_next = TCS_ST_IDLE;
			remain_next = 24'h00_0000;
		end

		// initialization overrides everything in flight
		if (init_valid && state_reg != TCS_ST_INIT)
		begin
			state_next = TCS_ST_INIT;
			drv_rst_next = 1'b1;
			itmr_next = INIT_CYC;
			busy_next = 1'b0;
			term_pend_next = 1'b0;
			remain_next = 24'h00_0000;
			err_code_next = `TCS_ERR_NONE;
			mot_start_next = 1'b0;
		end

		// ready is registered, so it looks at next-cycle room only
		hw_ready_next = (state_next == TCS_ST_WRITE) &&
			remain_next != 24'h00_0000 && !tw_valid_next;
		tr_ready_next = (state_next == TCS_ST_READ) &&
			remain_next != 24'h00_0000 && !hr_valid_next;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= TCS_ST_IDLE;
			mot_op_reg <= TCS_MOT_BOT;
			step_reg <= 2'h0;
			remain_reg <= 24'h00_0000;
			bib_reg <= 9'h000;
			blk_reg <= 24'h00_0000;
			err_code_reg <= `TCS_ERR_NONE;
			snap_reg <= 64'h0000_0000_0000_0000;
			sidx_reg <= 3'h0;
			itmr_reg <= 12'h000;
			sel_reg <= 1'b0;
			desel_seen_reg <= 1'b0;
			chg_reg <= 1'b1;
			at_eof_reg <= 1'b0;
			cart_q_reg <= 1'b0;
			term_pend_reg <= 1'b0;
			busy_reg <= 1'b0;
			cmd_ack_reg <= 1'b0;
			cmd_err_reg <= 1'b0;
			xfer_ack_reg <= 1'b0;
			xfer_err_reg <= 1'b0;
			poll_ack_reg <= 1'b0;
			poll_code_reg <= `TCS_POLL_BUSY;
			term_ack_reg <= 1'b0;
			term_err_reg <= 1'b0;
			init_ack_reg <= 1'b0;
			init_fail_reg <= 1'b0;
			hw_ready_reg <= 1'b0;
			tr_ready_reg <= 1'b0;
			hr_valid_reg <= 1'b0;
			tw_valid_reg <= 1'b0;
			tw_last_reg <= 1'b0;
			hr_data_reg <= 8'h00;
			tw_data_reg <= 8'h00;
			drv_rst_reg <= 1'b0;
			mot_start_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			mot_op_reg <= mot_op_next;
			step_reg <= step_next;
			remain_reg <= remain_next;
			bib_reg <= bib_next;
			blk_reg <= blk_next;
			err_code_reg <= err_code_next;
			snap_reg <= snap_next;
			sidx_reg <= sidx_next;
			itmr_reg <= itmr_next;
			sel_reg <= sel_next;
			desel_seen_reg <= desel_seen_next;
			chg_reg <= chg_next;
			at_eof_reg <= at_eof_next;
			cart_q_reg <= cart_q_next;
			term_pend_reg <= term_pend_next;
			busy_reg <= busy_next;
			cmd_ack_reg <= cmd_ack_next;
			cmd_err_reg <= cmd_err_next;
			xfer_ack_reg <= xfer_ack_next;
			xfer_err_reg <= xfer_err_next;
			poll_ack_reg <= poll_ack_next;
			poll_code_reg <= poll_code_next;
			term_ack_reg <= term_ack_next;
			term_err_reg <= term_err_next;
			init_ack_reg <= init_ack_next;
			init_fail_reg <= init_fail_next;
			hw_ready_reg <= hw_ready_next;
			tr_ready_reg <= tr_ready_next;
			hr_valid_reg <= hr_valid_next;
			tw_valid_reg <= tw_valid_next;
			tw_last_reg <= tw_last_next;
			hr_data_reg <= hr_data_next;
			tw_data_reg <= tw_data_next;
			drv_rst_reg <= drv_rst_next;
			mot_start_reg <= mot_start_next;
		end
	end

	assign cmd_ack = cmd_ack_reg;
	assign cmd_err = cmd_err_reg;
	assign xfer_ack = xfer_ack_reg;
	assign xfer_err = xfer_err_reg;
	assign poll_ack = poll_ack_reg;
	assign poll_code = poll_code_reg;
	assign term_ack = term_ack_reg;
	assign term_err = term_err_reg;
	assign init_ack = init_ack_reg;
	assign init_fail = init_fail_reg;
	assign busy = busy_reg;
	assign hw_ready = hw_ready_reg;
	assign hr_valid = hr_valid_reg;
	assign hr_data = hr_data_reg;
	assign drive_select = sel_reg;
	assign drive_reset = drv_rst_reg;
	assign mot_start = mot_start_reg;
	assign mot_op = mot_op_reg;
	assign tw_valid = tw_valid_reg;
	assign tw_data = tw_data_reg;
	assign tw_last = tw_last_reg;
	assign tr_ready = tr_ready_reg;

endmodule : tcs_sequencer
`default_nettype wire

// ### verification/tcs_sequencer_chk.sv
// port assertions of the tape command sequencer
`timescale 1ns/10ps
`default_nettype none
module tcs_sequencer_chk
	import tcs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// host side
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_ack,
	input wire logic cmd_err,
	input wire logic xfer_valid,
	input wire logic xfer_ack,
	input wire logic poll_valid,
	input wire logic poll_ack,
	input wire logic term_ack,
	input wire logic init_valid,
	input wire logic busy,
	// drive side
	input wire logic drive_select,
	input wire logic drive_reset,
	input wire logic mot_start,
	input wire tcs_pkg::tcs_mot_e mot_op,
	input wire logic tw_valid,
	input wire logic tw_last,
	input wire logic tw_ready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic known, free;
	logic [8:0] tw_cnt_reg, tw_cnt_next;
	assign known = cmd_code inside {8'h00, 8'h01, 8'h21, 8'h22, 8'h24, 8'h40,
		8'h60, 8'h80, 8'hA0, 8'hA3, 8'hC0, 8'hC1, 8'hC2};
	// a command that is neither refused for busy nor swallowed by init
	assign free = cmd_valid && !busy && !drive_reset;
	// ****************************************
	// bytes handed to the drive within a block
	// ****************************************
	always_comb
	begin
		tw_cnt_next = tw_cnt_reg;
		if (tw_valid && tw_ready)
			tw_cnt_next = tw_last ? 9'h000 : tw_cnt_reg + 9'h001;
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			tw_cnt_reg <= 9'h000;
		else
			tw_cnt_reg <= tw_cnt_next;
	end
	sequence bot_go;
		mot_start && mot_op == TCS_MOT_BOT;
	endsequence
	sequence motion_take(logic [7:0] c);
		free && drive_select && cmd_code == c;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	cmd_answer_a: assert property (cmd_valid && !drive_reset ##1 !cmd_valid |-> cmd_ack ##1 !cmd_ack)
		else $error("command not answered in one cycle");
	err_with_ack_a: assert property (cmd_err |-> cmd_ack)
		else $error("command error without answer");
	bad_code_a: assert property (free && !known |=> cmd_err && !mot_start && $stable(drive_select))
		else $error("unknown code not rejected cleanly");
	busy_refuse_a: assert property (cmd_valid && busy && !drive_reset |=> cmd_err)
		else $error("command while busy not refused");
	busy_end_a: assert property ($fell(busy) |-> term_ack || $past(init_valid))
		else $error("busy dropped without terminate");
	deselect_a: assert property (free && cmd_code == 8'h00 |=> !drive_select)
		else $error("deselect left drive selected");
	select_a: assert property (free && cmd_code == 8'h01 |=> drive_select)
		else $error("select did not raise drive select");
	rewind_bot_a: assert property (motion_take(8'h21) |-> ##[1:2] bot_go)
		else $error("rewind did not start toward start of tape");
	reten_bot_a: assert property (motion_take(8'h24) |-> ##[1:2] bot_go)
		else $error("retension did not start toward start of tape");
	poll_answer_a: assert property (poll_valid |=> poll_ack)
		else $error("poll not answered at once");
	xfer_answer_a: assert property (xfer_valid |=> xfer_ack)
		else $error("transfer start not answered");
	block_last_a: assert property (tw_valid && tw_ready |-> tw_last == (tw_cnt_reg == 9'h1FF))
		else $error("block end marker misplaced");
	init_reset_a: assert property (init_valid |=> drive_reset)
		else $error("init did not reset the drive");
endmodule : tcs_sequencer_chk
bind tcs_sequencer tcs_sequencer_chk u_chk (.*);
`default_nettype wire

// ### verification/tcs_drive_model.sv
// behavioural tape drive facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module tcs_drive_model
	import tcs_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// drive control
	input wire logic drive_reset,
	output logic drive_ready,
	output logic cart_present,
	input wire logic mot_start,
	input wire tcs_pkg::tcs_mot_e mot_op,
	output logic mot_done,
	output logic mot_err,
	// data to tape
	input wire logic tw_valid,
	input wire logic [7:0] tw_data,
	input wire logic tw_last,
	output logic tw_ready,
	// data from tape
	output logic tr_valid,
	output logic [7:0] tr_data,
	output logic tr_fmark,
	input wire logic tr_ready
);
	tcs_mot_e ops [$];
	int wcnt, wsum, lasts, rd_left, mcnt;
	logic [7:0] lf, junk;
	assign cart_present = 1'b1;
	assign mot_err = 1'b0;
	// one block, then a file mark; idle data keeps changing
	assign tr_valid = rd_left > 0;
	assign tr_fmark = rd_left == 0;
	assign tr_data = tr_valid ? rd_left[7:0] ^ 8'h5A : junk;
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drive_ready <= 1'b0;
			mot_done <= 1'b0;
			tw_ready <= 1'b0;
			mcnt <= 0;
			rd_left <= 512;
			lf <= 8'h5B;
			junk <= 8'h00;
		end
		else
		begin
			drive_ready <= drive_reset;
			lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
			junk <= junk + 8'h3B;
			tw_ready <= lf[0] | lf[1];
			mot_done <= mcnt == 1;
			if (mcnt > 0)
				mcnt <= mcnt - 1;
			if (tr_valid && tr_ready)
				rd_left <= rd_left - 1;
			if (mot_start)
			begin
				ops.push_back(mot_op);
				mcnt <= 3 + lf[2:0];
				if (mot_op == TCS_MOT_BOT || mot_op == TCS_MOT_SKIPFM)
					rd_left <= 512;
			end
			if (tw_valid && tw_ready)
			begin
				wcnt++;
				wsum += tw_data;
				lasts += tw_last;
			end
		end
	end
endmodule : tcs_drive_model
`default_nettype wire

// ### verification/test_tape_command_sequencer.sv
// self-checking bench of the tape command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tcs_cfg.svh"
module test_tape_command_sequencer;
	import tcs_pkg::*;
	logic clock, rst_n, cmd_valid, cmd_ack, cmd_err, xfer_valid, xfer_ack;
	logic xfer_err, poll_valid, poll_ack, term_valid, term_ack, term_err;
	logic init_valid, init_ack, init_fail, busy, hw_valid, hw_ready, wpend;
	logic hr_valid, hr_ready, drive_select, drive_reset, drive_ready;
	logic cart_present, mot_start, mot_done, mot_err, tw_valid, tw_last;
	logic tw_ready, tr_valid, tr_fmark, tr_ready;
	logic [7:0] cmd_code, hw_data, hr_data, tw_data, tr_data;
	logic [23:0] xfer_bytes;
	logic [1:0] poll_code;
	tcs_mot_e mot_op;
	logic [31:0] x, r;
	logic [7:0] rb [8];
	logic [7:0] mc [4];
	logic [8:0] mo [4];
	logic [8:0] got;
	int miscompares, checks_done, rcnt, rsum, wsum, wleft, i;
	tcs_sequencer uut (.*);
	tcs_drive_model drv (.*);
	always #2 clock = ~clock;
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd
	function automatic int rd_sum();
		int s;
		s = 0;
		for (int k = 1; k <= 512; k++)
			s += k[7:0] ^ 8'h5A;
		return s;
	endfunction : rd_sum
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask : chk
	// k picks the handshake: command, transfer, poll, terminate, init
	task automatic req(input int k, input logic [7:0] c, input logic [23:0] b);
		int t;
		logic a;
		@(negedge clock);
		cmd_code = c;
		xfer_bytes = b;
		{init_valid, term_valid, poll_valid, xfer_valid, cmd_valid} = 5'h01 << k;
		@(negedge clock);
		{init_valid, term_valid, poll_valid, xfer_valid, cmd_valid} = 5'h00;
		a = 1'b0;
		t = 0;
		while (!a && t < 30000)
		begin
			case (k)
				0: a = cmd_ack === 1'b1;
				1: a = xfer_ack === 1'b1;
				2: a = poll_ack === 1'b1;
				3: a = term_ack === 1'b1;
				default: a = init_ack === 1'b1;
			endcase
			if (!a)
				@(negedge clock);
			t++;
		end
		if (!a)
		begin
			miscompares++;
			close_out();
		end
	endtask : req
	task automatic cmd(input logic [7:0] c);
		req(0, c, 24'h00_0000);
	endtask : cmd
	task automatic term();
		req(3, 8'h00, 24'h00_0000);
	endtask : term
	task automatic poll_until(input logic [1:0] e);
		int n;
		n = 0;
		req(2, 8'h00, 24'h00_0000);
		while (poll_code === `TCS_POLL_BUSY && n < 2000)
		begin
			repeat (3) @(negedge clock);
			req(2, 8'h00, 24'h00_0000);
			n++;
		end
		if (n == 2000)
		begin
			miscompares++;
			close_out();
		end
		chk("poll code", e, poll_code);
	endtask : poll_until
	// ****************************************
	// host data streams, stalling at random
	// ****************************************
	always @(negedge clock)
	begin
		r = rnd();
		hr_ready = r[0] | r[1];
		if (hr_valid === 1'b1 && hr_ready)
		begin
			if (rcnt < 8)
				rb[rcnt] = hr_data;
			rsum += hr_data;
			rcnt++;
		end
		if (wpend)
		begin
			wleft--;
			hw_data = r[15:8];
		end
		hw_valid = wleft > 0;
		wpend = hw_valid && hw_ready === 1'b1;
		if (wpend)
			wsum += hw_data;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		x = 32'h0001_26C5;
		clock = 1'b0;
		rst_n = 1'b0;
		{init_valid, term_valid, poll_valid, xfer_valid, cmd_valid} = 5'h00;
		cmd_code = 8'h00;
		xfer_bytes = 24'h00_0000;
		wpend = 1'b0;
		mc = '{8'h22, 8'h24, 8'h60, 8'hA0};
		mo = '{{6'h00, TCS_MOT_ERASE}, {TCS_MOT_BOT, TCS_MOT_EOT, TCS_MOT_BOT},
			{6'h00, TCS_MOT_FMARK}, {6'h00, TCS_MOT_SKIPFM}};
		repeat (10) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		chk("busy", 0, busy);
		chk("drive select", 0, drive_select);
		req(4, 8'h00, 24'h00_0000);
		chk("init fail", 0, init_fail);
		cmd(8'h55);
		chk("bad code", 1, cmd_err);
		chk("select kept", 0, drive_select);
		cmd(`TCS_CMD_SEL);
		chk("drive select", 1, drive_select);
		term();
		drv.ops.delete();
		cmd(`TCS_CMD_REWIND);
		chk("busy", 1, busy);
		cmd(`TCS_CMD_ERASE);
		chk("early command", 1, cmd_err);
		term();
		chk("rewind motion", TCS_MOT_BOT, drv.ops[0]);
		for (i = 0; i < 4; i++)
		begin
			drv.ops.delete();
			cmd(mc[i]);
			term();
			got = 9'h000;
			for (int k = 0; k < drv.ops.size(); k++)
				got = {got[5:0], drv.ops[k]};
			chk("motion ops", mo[i], got);
			chk("motion count", i == 1 ? 3 : 1, drv.ops.size());
			chk("motion error", 0, term_err);
		end
		cmd(`TCS_CMD_WRITE);
		req(1, 8'h00, 24'h00_0200);
		chk("write start", 0, xfer_err);
		wleft = 512;
		poll_until(`TCS_POLL_DONE);
		term();
		chk("write error", 0, term_err);
		chk("bytes to tape", 512, drv.wcnt);
		chk("block ends", 1, drv.lasts);
		chk("tape data", wsum, drv.wsum);
		cmd(`TCS_CMD_WFMARK);
		term();
		cmd(`TCS_CMD_REWIND);
		term();
		cmd(`TCS_CMD_READ);
		req(1, 8'h00, 24'h00_0400);
		poll_until(`TCS_POLL_ERR);
		term();
		chk("read error", 1, term_err);
		chk("read bytes", 512, rcnt);
		chk("read data", rd_sum(), rsum);
		rcnt = 0;
		cmd(`TCS_CMD_READ);
		req(1, 8'h00, 24'h00_0200);
		poll_until(`TCS_POLL_ERR);
		term();
		chk("read past mark", 0, rcnt);
		cmd(`TCS_CMD_SKIPFM);
		term();
		chk("skip error", 0, term_err);
		cmd(`TCS_CMD_READ);
		req(1, 8'h00, 24'h00_0200);
		poll_until(`TCS_POLL_DONE);
		term();
		chk("next file bytes", 512, rcnt);
		for (i = 0; i < 2; i++)
		begin
			rcnt = 0;
			cmd(`TCS_CMD_SENSE);
			req(1, 8'h00, 24'h00_0200);
			poll_until(`TCS_POLL_DONE);
			term();
			chk("sense length", 8, rcnt);
		end
		for (i = 0; i < 8; i++)
			if (i != 4)
				chk("cleared sense", 0, rb[i]);
		chk("tape changed", 0, rb[4][7]);
		cmd(`TCS_CMD_DESEL);
		chk("drive select", 0, drive_select);
		term();
		cmd(`TCS_CMD_SEL);
		term();
		cmd(`TCS_CMD_READ);
		req(1, 8'h00, 24'h00_0200);
		poll_until(`TCS_POLL_ERR);
		term();
		chk("changed tape", 1, term_err);
		close_out();
	end
endmodule : test_tape_command_sequencer
`default_nettype wire
